// >>> hdl/pwr_mode_pkg.sv
// Constants for the power mode and reset controller.
// Assumes a 250 MHz clock and a plain register port with one-cycle read latency.
package pwr_mode_pkg;
	// ----------------------------------------
	// Register offsets (8-bit address)
	// ----------------------------------------
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CONV_CTRL = 8'h01;
	localparam logic [7:0] ADDR_ERROR_EN = 8'h02;
	localparam logic [7:0] ADDR_STBY_KEEP = 8'h03;
	localparam logic [7:0] ADDR_CHANNEL0 = 8'h04;
	localparam logic [7:0] ADDR_SETUP0 = 8'h05;
	localparam logic [7:0] ADDR_FILTER0 = 8'h06;
	localparam logic [7:0] ADDR_OUTPUTS = 8'h07;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] CONV_CTRL_RST = 16'h4000;
	localparam logic [15:0] ERROR_EN_RST = 16'h0001;
	localparam logic [15:0] STBY_KEEP_RST = 16'h0000;
	localparam logic [23:0] CHANNEL0_RST = 24'h80_0001;
	localparam logic [15:0] SETUP0_RST = 16'h0000;
	localparam logic [15:0] FILTER0_RST = 16'h0030;
	localparam logic [15:0] OUTPUTS_RST = 16'h0000;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MODE_LSB = 2;
	localparam int STATUS_RDY_BIT = 7;
	localparam int STATUS_DIP_BIT = 4;
	localparam int ERR_OSC_NEED_LSB = 1;
	localparam int KEEP_PIN_OUT = 0;
	localparam int KEEP_CHECKS = 1;
	localparam int KEEP_OUTPUTS = 2;
	localparam int KEEP_SWITCH = 3;
	localparam int KEEP_BURNOUT = 4;
	localparam int KEEP_BIAS = 5;
	localparam int KEEP_EXC = 6;
	localparam int KEEP_REF_HOLD = 7;
	localparam int KEEP_INT_REF = 8;
	localparam int CTRL_INT_REF_EN = 8;
	// ----------------------------------------
	// Mode codes
	// ----------------------------------------
	localparam logic [3:0] MODE_CONT = 4'h0;
	localparam logic [3:0] MODE_STANDBY = 4'h2;
	localparam logic [3:0] MODE_POWER_DOWN = 4'h3;
	localparam logic [3:0] MODE_IDLE = 4'h4;
	// ----------------------------------------
	// Software reset pattern length
	// ----------------------------------------
	localparam int SW_RESET_ONES = 64;
endpackage

// >>> hdl/power_mode_reset_control.sv
// Power mode, reset and standby keep control of a sigma-delta converter.
// Assumes inputs synchronous to clk; serial bits arrive as one-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Digital supply first applied resets configuration
// - Digital supply or regulator dip resets
// - Dip flag set, cleared by status read
// - Channel 0 defaults: enabled, inputs 0/1
// - Setup 0 defaults: currents off, gain 1
// - Filter 0 default sinc3, rate 0x30
// - Converter control defaults as listed
// - Only early-transaction check enabled after reset
// - Mode codes 2,3,4: standby, down, idle
// - Power-down powers off every block
// - Power-down only from standby, else continuous
// - Idle holds modulator and filter reset
// - New mode code leaves idle or standby
// - Standby keeps registers, ready bar high
// - Standby indication onto output pin two
// - Keep checks and oscillator in standby
// - Keep general outputs in standby
// - Keep power switch in standby
// - Keep open-wire current in standby
// - Keep bias generator and excitation
// - Internal reference needs both keep bits
// - 64 consecutive ones cause software reset
module power_mode_reset_control (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Supply monitors
	input wire logic digital_io_supply_ok,
	input wire logic digital_reg_ok,
	input wire logic analog_supply_ok,
	// Serial input bit stream
	input wire logic serial_bit_valid,
	input wire logic serial_bit,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [23:0] reg_rdata,
	// Converter status
	input wire logic conv_result_ready,
	// Block enables
	output logic modulator_reset,
	output logic filter_reset,
	output logic analog_power_en,
	output logic checks_en,
	output logic oscillator_en,
	output logic general_outputs_en,
	output logic power_switch_en,
	output logic open_wire_current_en,
	output logic bias_gen_en,
	output logic excitation_en,
	output logic internal_reference_en,
	output logic general_output_pin_two,
	output logic in_power_down,
	output logic in_standby
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [15:0] conv_ctrl_ff, nxt_conv_ctrl; // Converter control
	logic [15:0] error_en_ff, nxt_error_en; // Check enables
	logic [15:0] stby_keep_ff, nxt_stby_keep; // Standby keep bits
	logic [23:0] channel0_ff, nxt_channel0; // Channel slot 0
	logic [15:0] setup0_ff, nxt_setup0; // Setup 0
	logic [15:0] filter0_ff, nxt_filter0; // Filter 0
	logic [15:0] outputs_ff, nxt_outputs; // General output control
	logic dip_flag_ff, nxt_dip_flag; // Sticky supply dip flag
	logic [6:0] ones_cnt_ff, nxt_ones_cnt; // Consecutive ones
	logic [23:0] rdata_nxt; // Read data next
	logic supply_ok; // Digital side healthy
	logic sw_reset; // Software reset pulse
	logic [3:0] mode; // Current mode field
	logic standby; // In standby
	logic [15:0] ctrl_after_write; // Written control value
	// Registered enables, one flop per output
	logic nxt_mod_rst, mod_rst_ff; // Modulator reset
	logic nxt_filt_rst, filt_rst_ff; // Filter reset
	logic nxt_analog_on, analog_on_ff; // Analog side enable
	logic nxt_checks_on, checks_on_ff; // Diagnostics enable
	logic nxt_osc_on, osc_on_ff; // Oscillator enable
	logic nxt_outs_on, outs_on_ff; // General outputs enable
	logic nxt_switch_on, switch_on_ff; // Bridge switch enable
	logic nxt_wire_cur_on, wire_cur_on_ff; // Open-wire current enable
	logic nxt_bias_on, bias_on_ff; // Bias generator enable
	logic nxt_exc_on, exc_on_ff; // Excitation enable
	logic nxt_iref_on, iref_on_ff; // Internal reference enable
	logic nxt_pin_two, pin_two_ff; // Output pin two level
	logic nxt_down, down_ff; // Power-down indication
	logic nxt_stby_flag, stby_flag_ff; // Standby indication
	logic is_down; // Mode is power-down
	logic is_idle; // Mode is idle
	logic osc_checks_on; // An enabled check needs the oscillator

	// Mode field position, named once for the part-selects below
	localparam int MODE_LSB_C = pwr_mode_pkg::MODE_LSB;

	// Digital supply or regulator loss resets; analog dips ignored
	assign supply_ok = digital_io_supply_ok & digital_reg_ok;
	// Mode field decode shared by writes, reads and enables
	assign mode = conv_ctrl_ff[MODE_LSB_C +: 4];
	assign standby = (mode == pwr_mode_pkg::MODE_STANDBY);

	// ----------------------------------------
	// Software reset detector
	// ----------------------------------------
	// Counts ones; any zero restarts the run
	// The count restarts after each reset pulse, so a longer run
	// of ones resets again only after another full pattern
	always_comb begin
		nxt_ones_cnt = ones_cnt_ff;
		sw_reset = 1'b0;
		if (serial_bit_valid) begin
			if (!serial_bit) begin
				nxt_ones_cnt = 7'h00;
			end else if (ones_cnt_ff == 7'(pwr_mode_pkg::SW_RESET_ONES - 1)) begin
				nxt_ones_cnt = 7'h00;
				sw_reset = 1'b1;
			end else begin
				nxt_ones_cnt = ones_cnt_ff + 7'h01;
			end
		end
	end

	// Ones counter register
	always_ff @(posedge clk) begin
		if (!reset_n || !supply_ok) begin
			ones_cnt_ff <= 7'h00;
		end else begin
			ones_cnt_ff <= nxt_ones_cnt;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Mode write filter: power-down only from standby
	// A stray power-down code from a running mode lands as
	// continuous conversion, so the part never drops out by accident
	always_comb begin
		ctrl_after_write = reg_wdata[15:0];
		if (reg_wdata[MODE_LSB_C +: 4] == pwr_mode_pkg::MODE_POWER_DOWN && !standby) begin
			ctrl_after_write[MODE_LSB_C +: 4] = pwr_mode_pkg::MODE_CONT;
		end
	end

	// Next register values
	always_comb begin
		nxt_conv_ctrl = conv_ctrl_ff;
		nxt_error_en = error_en_ff;
		nxt_stby_keep = stby_keep_ff;
		nxt_channel0 = channel0_ff;
		nxt_setup0 = setup0_ff;
		nxt_filter0 = filter0_ff;
		nxt_outputs = outputs_ff;
		nxt_dip_flag = dip_flag_ff;
		// Status read clears the dip flag
		if (reg_rd && reg_addr == pwr_mode_pkg::ADDR_STATUS) begin
			nxt_dip_flag = 1'b0;
		end
		// Power-down ignores writes until reset
		if (reg_wr && mode != pwr_mode_pkg::MODE_POWER_DOWN) begin
			unique case (reg_addr)
				pwr_mode_pkg::ADDR_CONV_CTRL: begin
					nxt_conv_ctrl = ctrl_after_write;
				end
				pwr_mode_pkg::ADDR_ERROR_EN: nxt_error_en = reg_wdata[15:0];
				pwr_mode_pkg::ADDR_STBY_KEEP: nxt_stby_keep = reg_wdata[15:0];
				pwr_mode_pkg::ADDR_CHANNEL0: nxt_channel0 = reg_wdata;
				pwr_mode_pkg::ADDR_SETUP0: nxt_setup0 = reg_wdata[15:0];
				pwr_mode_pkg::ADDR_FILTER0: nxt_filter0 = reg_wdata[15:0];
				pwr_mode_pkg::ADDR_OUTPUTS: nxt_outputs = reg_wdata[15:0];
				default: begin
				end
			endcase
		end
	end

	// Register file: power-on and software reset load one default set
	always_ff @(posedge clk) begin
		if (!reset_n || !supply_ok || sw_reset) begin
			conv_ctrl_ff <= pwr_mode_pkg::CONV_CTRL_RST;
			error_en_ff <= pwr_mode_pkg::ERROR_EN_RST;
			stby_keep_ff <= pwr_mode_pkg::STBY_KEEP_RST;
			channel0_ff <= pwr_mode_pkg::CHANNEL0_RST;
			setup0_ff <= pwr_mode_pkg::SETUP0_RST;
			filter0_ff <= pwr_mode_pkg::FILTER0_RST;
			outputs_ff <= pwr_mode_pkg::OUTPUTS_RST;
		end else begin
			conv_ctrl_ff <= nxt_conv_ctrl;
			error_en_ff <= nxt_error_en;
			stby_keep_ff <= nxt_stby_keep;
			channel0_ff <= nxt_channel0;
			setup0_ff <= nxt_setup0;
			filter0_ff <= nxt_filter0;
			outputs_ff <= nxt_outputs;
		end
	end

	// Dip flag: set by any reset event, set wins over read clear
	// A status read in the same cycle as a reset leaves the flag set
	always_ff @(posedge clk) begin
		if (!reset_n || !supply_ok || sw_reset) begin
			dip_flag_ff <= 1'b1;
		end else begin
			dip_flag_ff <= nxt_dip_flag;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Read data mux; unmapped reads zero
	// Data stand for the one cycle after the read and are zero otherwise
	always_comb begin
		rdata_nxt = 24'h00_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				pwr_mode_pkg::ADDR_STATUS: begin
					// Ready bar forced high in standby
					rdata_nxt[pwr_mode_pkg::STATUS_RDY_BIT] = standby | ~conv_result_ready;
					rdata_nxt[pwr_mode_pkg::STATUS_DIP_BIT] = dip_flag_ff;
				end
				pwr_mode_pkg::ADDR_CONV_CTRL: rdata_nxt[15:0] = conv_ctrl_ff;
				pwr_mode_pkg::ADDR_ERROR_EN: rdata_nxt[15:0] = error_en_ff;
				pwr_mode_pkg::ADDR_STBY_KEEP: rdata_nxt[15:0] = stby_keep_ff;
				pwr_mode_pkg::ADDR_CHANNEL0: rdata_nxt = channel0_ff;
				pwr_mode_pkg::ADDR_SETUP0: rdata_nxt[15:0] = setup0_ff;
				pwr_mode_pkg::ADDR_FILTER0: rdata_nxt[15:0] = filter0_ff;
				pwr_mode_pkg::ADDR_OUTPUTS: rdata_nxt[15:0] = outputs_ff;
				default: begin
				end
			endcase
		end
	end

	// Read data register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			reg_rdata <= 24'h00_0000;
		end else begin
			reg_rdata <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// Block enables
	// ----------------------------------------
	// Continuous conversion runs every block the control word allows.
	// Idle only holds the converter core in reset; registers stay.
	// Standby also drops the analog side, except for the blocks
	// whose keep bit is set. Power-down silences every block, keep
	// bits included, until a reset brings the part back; pin two
	// still follows its data bit unless it shows standby.
	// All enables are registered, so they follow a mode write
	// one cycle after the write edge.

	// A block stays on outside standby, or in standby with its keep bit
	function automatic logic kept_on(input logic in_stby, input logic keep_bit);
		// Keep bits only matter in standby
		return ~in_stby | keep_bit;
	endfunction

	// Mode classes shared by several enables
	assign is_down = (mode == pwr_mode_pkg::MODE_POWER_DOWN);
	assign is_idle = (mode == pwr_mode_pkg::MODE_IDLE);

	// Oscillator demand: any enabled check above the early-transaction one
	assign osc_checks_on = |error_en_ff[15:pwr_mode_pkg::ERR_OSC_NEED_LSB];

	// Next enables from mode and keep bits
	always_comb begin
		// Converter core held in reset outside conversion
		nxt_mod_rst = is_idle | standby | is_down;
		nxt_filt_rst = is_idle | standby | is_down;
		// Analog side off in standby and power-down
		nxt_analog_on = ~(standby | is_down);
		// Diagnostics, and the oscillator they need
		nxt_checks_on = ~is_down & kept_on(standby, stby_keep_ff[pwr_mode_pkg::KEEP_CHECKS]);
		nxt_osc_on = ~is_down & kept_on(standby, stby_keep_ff[pwr_mode_pkg::KEEP_CHECKS]
			& osc_checks_on);
		// Output pins and bridge switch
		nxt_outs_on = ~is_down & kept_on(standby, stby_keep_ff[pwr_mode_pkg::KEEP_OUTPUTS]);
		nxt_switch_on = ~is_down & kept_on(standby, stby_keep_ff[pwr_mode_pkg::KEEP_SWITCH]);
		// Sensor currents and bias
		nxt_wire_cur_on = ~is_down & kept_on(standby, stby_keep_ff[pwr_mode_pkg::KEEP_BURNOUT]);
		nxt_bias_on = ~is_down & kept_on(standby, stby_keep_ff[pwr_mode_pkg::KEEP_BIAS]);
		nxt_exc_on = ~is_down & kept_on(standby, stby_keep_ff[pwr_mode_pkg::KEEP_EXC]);
		// Internal reference: enabled by control, kept only with both bits
		nxt_iref_on = ~is_down & conv_ctrl_ff[pwr_mode_pkg::CTRL_INT_REF_EN]
			& kept_on(standby, stby_keep_ff[pwr_mode_pkg::KEEP_REF_HOLD]
			& stby_keep_ff[pwr_mode_pkg::KEEP_INT_REF]);
		// Pin two shows standby when asked, else its data bit
		if (stby_keep_ff[pwr_mode_pkg::KEEP_PIN_OUT]) begin
			nxt_pin_two = standby;
		end else begin
			nxt_pin_two = outputs_ff[0];
		end
		// Mode indications
		nxt_down = is_down;
		nxt_stby_flag = standby;
	end

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	// Enable flops; reset leaves the analog side on and the rest off
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			// Core resets low, analog side powered
			mod_rst_ff <= 1'b0;
			filt_rst_ff <= 1'b0;
			analog_on_ff <= 1'b1;
			// Keepable blocks off until the first decode
			checks_on_ff <= 1'b0;
			osc_on_ff <= 1'b0;
			outs_on_ff <= 1'b0;
			switch_on_ff <= 1'b0;
			wire_cur_on_ff <= 1'b0;
			bias_on_ff <= 1'b0;
			exc_on_ff <= 1'b0;
			iref_on_ff <= 1'b0;
			pin_two_ff <= 1'b0;
			// Indications clear
			down_ff <= 1'b0;
			stby_flag_ff <= 1'b0;
		end else begin
			// Follow the decoded enables
			mod_rst_ff <= nxt_mod_rst;
			filt_rst_ff <= nxt_filt_rst;
			analog_on_ff <= nxt_analog_on;
			checks_on_ff <= nxt_checks_on;
			osc_on_ff <= nxt_osc_on;
			outs_on_ff <= nxt_outs_on;
			switch_on_ff <= nxt_switch_on;
			wire_cur_on_ff <= nxt_wire_cur_on;
			bias_on_ff <= nxt_bias_on;
			exc_on_ff <= nxt_exc_on;
			iref_on_ff <= nxt_iref_on;
			pin_two_ff <= nxt_pin_two;
			down_ff <= nxt_down;
			stby_flag_ff <= nxt_stby_flag;
		end
	end

	// Every output straight from its flop
	// Converter core
	assign modulator_reset = mod_rst_ff;
	assign filter_reset = filt_rst_ff;

	// Power and clocks
	assign analog_power_en = analog_on_ff;
	assign checks_en = checks_on_ff;
	assign oscillator_en = osc_on_ff;

	// Keepable blocks
	assign general_outputs_en = outs_on_ff;
	assign power_switch_en = switch_on_ff;
	assign open_wire_current_en = wire_cur_on_ff;
	assign bias_gen_en = bias_on_ff;
	assign excitation_en = exc_on_ff;
	assign internal_reference_en = iref_on_ff;

	// Pin and indications
	assign general_output_pin_two = pin_two_ff;
	assign in_power_down = down_ff;
	assign in_standby = stby_flag_ff;
endmodule
`default_nettype wire

// >>> tb/pwr_mode_monitor.sv
// Checker of the power mode and reset controller, seeing its ports only.
// Assumes a bind onto power_mode_reset_control; one clock, reset_n low active.
`timescale 1ns/10ps
`default_nettype none
module pwr_mode_monitor (
	// Clock, reset and register port
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [23:0] reg_rdata,
	// Outputs watched
	input wire logic modulator_reset,
	input wire logic filter_reset,
	input wire logic analog_power_en,
	input wire logic checks_en,
	input wire logic oscillator_en,
	input wire logic internal_reference_en,
	input wire logic in_power_down,
	input wire logic in_standby
);
	// ----------------------------------------
	// Mode write decode
	// ----------------------------------------
	logic mw; // Converter control written
	logic [3:0] mc; // Mode code of that write
	assign mw = reg_wr && reg_addr == pwr_mode_pkg::ADDR_CONV_CTRL;
	assign mc = reg_wdata[5:2];
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_reset_state: assert property (!$past(reset_n) |-> analog_power_en && !in_standby && !in_power_down)
		else $error("outputs not in reset state");
	a_release_cont: assert property ($rose(reset_n) |-> ##2 !modulator_reset && analog_power_en && !internal_reference_en)
		else $error("not continuous after release");
	a_standby_entry: assert property (mw && mc == 4'h2 && !in_power_down ##1 !reg_wr [*2] |-> ##1 in_standby && modulator_reset && !analog_power_en)
		else $error("standby not entered");
	a_idle_holds: assert property (mw && mc == 4'h4 && !in_power_down ##1 !reg_wr [*2] |-> ##1 modulator_reset && filter_reset && !in_standby)
		else $error("idle does not hold resets");
	a_down_refused: assert property (mw && mc == 4'h3 && !in_standby && !in_power_down ##1 !reg_wr [*2] |-> ##1 !in_power_down && !modulator_reset)
		else $error("power-down entered outside standby");
	a_down_entry: assert property (mw && mc == 4'h3 && in_standby ##1 !reg_wr [*2] |-> ##1 in_power_down && !analog_power_en && !checks_en && !oscillator_en)
		else $error("power-down left blocks on");
	a_down_sticky: assert property (in_power_down && mw |-> ##3 in_power_down)
		else $error("write left power-down");
	a_standby_rdy: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 && $past(in_standby) |-> reg_rdata[7])
		else $error("ready bar low in standby");
endmodule
bind power_mode_reset_control pwr_mode_monitor pwr_mode_monitor_i (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .modulator_reset, .filter_reset, .analog_power_en, .checks_en, .oscillator_en,
	.internal_reference_en, .in_power_down, .in_standby);
`default_nettype wire

// >>> tb/reg_host.sv
// Host model: register port master and serial bit source.
// Assumes the slave answers reads in the following cycle.
`timescale 1ns/10ps
`default_nettype none
module reg_host (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic [23:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [23:0] reg_rdata,
	// Serial bits
	output logic serial_bit_valid,
	output logic serial_bit
);
	// Idle bus at time zero
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, serial_bit_valid, serial_bit} = '0;
	end
	// One write, data released to its inverse after
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	// One read, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [23:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
	// Run of n equal serial bits; 64 ones make a software reset
	task automatic ser(input int n, input logic b);
		repeat (n) begin
			@(posedge clk);
			serial_bit_valid <= 1'b1;
			serial_bit <= b;
		end
		@(posedge clk);
		serial_bit_valid <= 1'b0;
		serial_bit <= ~b;
	endtask
endmodule
`default_nettype wire

// >>> tb/power_mode_reset_control_test.sv
// Testbench of the power mode and reset controller.
// Assumes reg_host as host model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module power_mode_reset_control_test;
	logic clk, reset_n, digital_io_supply_ok, digital_reg_ok, analog_supply_ok, conv_result_ready;
	logic serial_bit_valid, serial_bit, reg_wr, reg_rd;
	logic [7:0] reg_addr;
	logic [23:0] reg_wdata, reg_rdata, s;
	logic modulator_reset, filter_reset, analog_power_en, checks_en, oscillator_en, general_outputs_en;
	logic power_switch_en, open_wire_current_en, bias_gen_en, excitation_en, internal_reference_en;
	logic general_output_pin_two, in_power_down, in_standby;
	int errors = 0;
	int comparisons = 0;
	power_mode_reset_control power_mode_reset_control_i (.clk, .reset_n, .digital_io_supply_ok, .digital_reg_ok,
		.analog_supply_ok, .serial_bit_valid, .serial_bit, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.conv_result_ready, .modulator_reset, .filter_reset, .analog_power_en, .checks_en, .oscillator_en,
		.general_outputs_en, .power_switch_en, .open_wire_current_en, .bias_gen_en, .excitation_en,
		.internal_reference_en, .general_output_pin_two, .in_power_down, .in_standby);
	reg_host reg_host_i (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .serial_bit_valid, .serial_bit);
	// ----------------------------------------
	// Clock, compare, verdict
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic settle;
		repeat (3) @(posedge clk);
	endtask
	task automatic final_report;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#100000;
		errors++;
		final_report;
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		logic [23:0] d, e;
		logic [23:0] dflt [8];
		logic [8:0] keeps [12];
		keeps = '{9'h000, 9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100, 9'h180, 9'h1ff};
		dflt = '{'0, 24'(pwr_mode_pkg::CONV_CTRL_RST), 24'(pwr_mode_pkg::ERROR_EN_RST), 24'(pwr_mode_pkg::STBY_KEEP_RST),
			pwr_mode_pkg::CHANNEL0_RST, 24'(pwr_mode_pkg::SETUP0_RST), 24'(pwr_mode_pkg::FILTER0_RST), 24'(pwr_mode_pkg::OUTPUTS_RST)};
		{reset_n, digital_io_supply_ok, digital_reg_ok, analog_supply_ok, conv_result_ready} = 5'b01111;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		settle;
		chk({20'h0_0000, modulator_reset, filter_reset, analog_power_en, internal_reference_en}, 24'h00_0002);
		reg_host_i.rd(8'h00, d);
		chk(d & 24'h00_0090, 24'h00_0010);
		reg_host_i.rd(8'h00, d);
		chk(d & 24'h00_0090, 24'h00_0000);
		for (int a = 1; a < 8; a++) begin
			reg_host_i.rd(8'(a), d);
			chk(d, dflt[a]);
		end
		reg_host_i.rd(8'h40, d);
		chk(d, 24'h00_0000);
		// Standby with internal reference on, then each keep bit
		reg_host_i.wr(8'h01, 24'h00_4108);
		settle;
		reg_host_i.rd(8'h00, d);
		chk(d & 24'h00_0080, 24'h00_0080);
		foreach (keeps[i]) begin
			reg_host_i.wr(8'h03, {15'h0000, keeps[i]});
			settle;
			s = {15'h0000, in_standby, internal_reference_en, excitation_en, bias_gen_en, open_wire_current_en,
				power_switch_en, general_outputs_en, checks_en, general_output_pin_two};
			e = {16'h0001, keeps[i][8] & keeps[i][7], keeps[i][6:0]};
			chk(s & 24'h00_0107, e & 24'h00_0107);
			chk(s & 24'h00_00f8, e & 24'h00_00f8);
		end
		chk({23'h00_0000, oscillator_en}, 24'h00_0000);
		reg_host_i.wr(8'h02, 24'h00_0003);
		settle;
		chk({23'h00_0000, oscillator_en}, 24'h00_0001);
		// Idle, then power-down code outside standby
		reg_host_i.wr(8'h01, 24'h00_4010);
		settle;
		chk({21'h00_0000, in_standby, modulator_reset, filter_reset}, 24'h00_0003);
		reg_host_i.rd(8'h06, d);
		chk(d, 24'(pwr_mode_pkg::FILTER0_RST));
		reg_host_i.wr(8'h01, 24'h00_400C);
		settle;
		chk({22'h00_0000, in_power_down, modulator_reset}, 24'h00_0000);
		// Standby first, then power-down, mode write refused
		reg_host_i.wr(8'h01, 24'h00_4008);
		settle;
		reg_host_i.wr(8'h01, 24'h00_400C);
		settle;
		chk({21'h00_0000, in_power_down, analog_power_en, checks_en}, 24'h00_0004);
		reg_host_i.wr(8'h01, 24'h00_4000);
		settle;
		chk({23'h00_0000, in_power_down}, 24'h00_0001);
		reg_host_i.ser(63, 1'b1);
		reg_host_i.ser(1, 1'b0);
		settle;
		chk({23'h00_0000, in_power_down}, 24'h00_0001);
		reg_host_i.ser(64, 1'b1);
		settle;
		chk({23'h00_0000, in_power_down}, 24'h00_0000);
		reg_host_i.rd(8'h00, d);
		chk(d & 24'h00_0010, 24'h00_0010);
		reg_host_i.rd(8'h03, d);
		chk(d, 24'h00_0000);
		// Supply dips: analog, digital regulator, digital supply
		for (int k = 0; k < 3; k++) begin
			reg_host_i.wr(8'h03, 24'h00_0005);
			analog_supply_ok <= (k != 0);
			digital_reg_ok <= (k != 1);
			digital_io_supply_ok <= (k != 2);
			@(posedge clk);
			{analog_supply_ok, digital_reg_ok, digital_io_supply_ok} <= 3'b111;
			settle;
			reg_host_i.rd(8'h03, d);
			chk(d, (k == 0) ? 24'h00_0005 : 24'h00_0000);
			reg_host_i.rd(8'h00, d);
			chk(d & 24'h00_0010, (k == 0) ? 24'h00_0000 : 24'h00_0010);
		end
		final_report;
	end
endmodule
`default_nettype wire
